//--- verilog/pdmm_top.v
// Purpose: Digital microphone input unit: pins, registers, capture, memory writes
// Assumes: 10 MHz clk, synchronous active-low reset, 32 pins
// Notes:   Decimation is a simple one-count per 64-bit frame
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "pdmm_map.vh"

module pdmm_top
(
  input  wire        clk,
  input  wire        resetn,
  input  wire [11:0] reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  input  wire        power_off,
  input  wire [31:0] gpio_out,
  input  wire [31:0] gpio_oe,
  input  wire [31:0] pin_in,
  output reg  [31:0] pin_out,
  output reg  [31:0] pin_oe,
  output reg  [31:0] mem_addr,
  output reg  [31:0] mem_wdata,
  output reg         mem_we,
  output reg         irq
);

  localparam ST_IDLE = 1'b0; // Not capturing
  localparam ST_RUN  = 1'b1; // Capturing

  // Software registers
  reg        en_r;       // Unit enable
  reg [7:0]  clkctl_r;   // Bit clock half period
  reg [1:0]  mode_r;     // Mono and edge swap
  reg [6:0]  left_gain_r;    // Left gain, stored only
  reg [6:0]  right_gain_r;    // Right gain, stored only
  reg [31:0] psel_clk_r; // Clock pin select
  reg [31:0] psel_din_r; // Data pin select
  reg [31:0] ptr_r;      // Next buffer pointer
  reg [15:0] max_r;      // Next buffer length
  reg [2:0]  ev_r;       // Sticky event flags
  reg [2:0]  irq_enable_r;    // Interrupt enables

  // Capture state
  reg        state_r;    // Idle or run
  reg        stop_req_r; // Stop pending
  reg [31:0] act_ptr_r;  // Live write pointer
  reg [15:0] act_max_r;  // Live buffer length
  reg [15:0] cnt_r;      // Samples in live buffer
  reg [5:0]  bit_r;      // Bit clock periods in frame
  reg        frame_r;    // Frame complete pulse
  reg [6:0]  accl_r;     // Left ones count
  reg [6:0]  accr_r;     // Right ones count
  reg        half_r;     // Mono low half held
  reg [15:0] hold_r;     // Held mono sample
  reg [2:0]  ev_set_r;   // Event pulses to flags

  // Internal wires
  wire        bclk;      // Generated bit clock
  wire        rise;      // Bit clock rising pulse
  wire        fall;      // Bit clock falling pulse
  wire [31:0] pin_s;     // Synchronised pins
  wire        clk_conn;  // Clock pin attached
  wire        din_conn;  // Data pin attached
  wire        din;       // Selected data bit
  wire        start_hit; // Start trigger written
  wire        stop_hit;  // Stop trigger written
  wire [15:0] samp_l;    // Left frame sample
  wire [15:0] samp_r;    // Right frame sample
  wire [16:0] cnt_n;     // Count after this frame
  wire        full;      // Buffer reaches length
  wire        wr_word;   // Word goes to memory
  wire [31:0] word;      // Word to write
  reg  [2:0]  ev_wr;     // Software writes a flag

  // Pin inputs pass two flops before use
  pdmm_sync #(.W(32)) u_sync
  (
    .clk      (clk),
    .resetn   (resetn),
    .async_in (pin_in),
    .sync_out (pin_s)
  );

  // Bit clock runs only while capturing
  pdmm_bclk u_bclk
  (
    .clk         (clk),
    .resetn      (resetn),
    .run         (state_r == ST_RUN),
    .half_period (clkctl_r),
    .bclk        (bclk),
    .rise        (rise),
    .fall        (fall)
  );

  // Attachment only while enabled and connected
  assign clk_conn = en_r & ~psel_clk_r[`PDMM_PSEL_DISC];
  assign din_conn = en_r & ~psel_din_r[`PDMM_PSEL_DISC];
  assign din = din_conn ? pin_s[psel_din_r[4:0]] : 1'b0;

  // Triggers act only on a written one
  assign start_hit = reg_wr && (reg_addr == `PDMM_A_START) && reg_wdata[0];
  assign stop_hit  = reg_wr && (reg_addr == `PDMM_A_STOP) && reg_wdata[0];

  // Ones count centred to a signed sample
  assign samp_l = {accl_r, 9'h000} ^ 16'h8000;
  assign samp_r = {accr_r, 9'h000} ^ 16'h8000;

  // Stereo takes two samples, mono one
  assign cnt_n = {1'b0, cnt_r} + (mode_r[`PDMM_MODE_MONO] ? 17'h00001 : 17'h00002);
  assign full  = cnt_n >= {1'b0, act_max_r};

  // Mono pairs samples; a partial word flushes at end or stop
  assign wr_word = ~mode_r[`PDMM_MODE_MONO] | half_r | full | stop_req_r;
  assign word = ~mode_r[`PDMM_MODE_MONO] ? {samp_r, samp_l} :
                half_r ? {samp_l, hold_r} : {16'h0000, samp_l};

  // Which flag addresses software writes
  always @*
  begin
    ev_wr = 3'b000;
    if (reg_wr && reg_addr == `PDMM_A_EV_STA)
      ev_wr[`PDMM_EV_STARTED] = 1'b1;
    else if (reg_wr && reg_addr == `PDMM_A_EV_STO)
      ev_wr[`PDMM_EV_STOPPED] = 1'b1;
    else if (reg_wr && reg_addr == `PDMM_A_EV_END)
      ev_wr[`PDMM_EV_END] = 1'b1;
  end

  // Configuration registers
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      en_r       <= 1'b0;
      clkctl_r   <= `PDMM_CLKCTL_RST;
      mode_r     <= 2'b00;
      left_gain_r    <= `PDMM_GAIN_RST;
      right_gain_r    <= `PDMM_GAIN_RST;
      psel_clk_r <= `PDMM_PSEL_RST;
      psel_din_r <= `PDMM_PSEL_RST;
      ptr_r      <= 32'h00000000;
      max_r      <= 16'h0000;
      irq_enable_r    <= 3'b000;
    end
    else
    begin
      if (reg_wr)
      begin
        // Address decode for plain writes
        if (reg_addr == `PDMM_A_IRQ_ENABLE)
          irq_enable_r <= reg_wdata[2:0];
        else if (reg_addr == `PDMM_A_INTSET)
          irq_enable_r <= irq_enable_r | reg_wdata[2:0];
        else if (reg_addr == `PDMM_A_INTCLR)
          irq_enable_r <= irq_enable_r & ~reg_wdata[2:0];
        else if (reg_addr == `PDMM_A_ENABLE)
          en_r <= reg_wdata[0];
        else if (reg_addr == `PDMM_A_CLKCTL)
          clkctl_r <= reg_wdata[7:0];
        else if (reg_addr == `PDMM_A_MODE)
          mode_r <= reg_wdata[1:0];
        else if (reg_addr == `PDMM_A_LEFT_GAIN)
          left_gain_r <= reg_wdata[6:0];
        else if (reg_addr == `PDMM_A_RIGHT_GAIN)
          right_gain_r <= reg_wdata[6:0];
        else if (reg_addr == `PDMM_A_PSELCLK)
          psel_clk_r <= reg_wdata;
        else if (reg_addr == `PDMM_A_PSELDIN)
          psel_din_r <= reg_wdata;
        else if (reg_addr == `PDMM_A_PTR)
          ptr_r <= reg_wdata;
        else if (reg_addr == `PDMM_A_MAXCNT)
          max_r <= reg_wdata[15:0];
      end
      // Pin selects do not survive power off, and this wins over a write
      if (power_off)
      begin
        psel_clk_r <= `PDMM_PSEL_RST;
        psel_din_r <= `PDMM_PSEL_RST;
      end
    end
  end

  // Sticky flags; a hardware set wins over a same-cycle clear
  always @(posedge clk)
  begin
    if (!resetn)
      ev_r <= 3'b000;
    else
      ev_r <= ((ev_r & ~ev_wr) | (ev_wr & {3{reg_wdata[0]}})) | ev_set_r;
  end

  // Level interrupt from enabled flags
  always @(posedge clk)
  begin
    if (!resetn)
      irq <= 1'b0;
    else
      irq <= |(ev_r & irq_enable_r);
  end

  // Capture sequencer, sampling and memory writes
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      state_r    <= ST_IDLE;
      stop_req_r <= 1'b0;
      act_ptr_r  <= 32'h00000000;
      act_max_r  <= 16'h0000;
      cnt_r      <= 16'h0000;
      bit_r      <= 6'h00;
      frame_r    <= 1'b0;
      accl_r     <= 7'h00;
      accr_r     <= 7'h00;
      half_r     <= 1'b0;
      hold_r     <= 16'h0000;
      ev_set_r   <= 3'b000;
      mem_we     <= 1'b0;
      mem_addr   <= 32'h00000000;
      mem_wdata  <= 32'h00000000;
    end
    else
    begin
      ev_set_r <= 3'b000;
      mem_we   <= 1'b0;
      frame_r  <= 1'b0;
      case (state_r)
        ST_IDLE:
        begin
          stop_req_r <= 1'b0;
          bit_r      <= 6'h00;
          accl_r     <= 7'h00;
          accr_r     <= 7'h00;
          half_r     <= 1'b0;
          // A start latches the buffer and reports it
          if (start_hit && en_r)
          begin
            state_r                   <= ST_RUN;
            act_ptr_r                 <= ptr_r;
            act_max_r                 <= max_r;
            cnt_r                     <= 16'h0000;
            ev_set_r[`PDMM_EV_STARTED] <= 1'b1;
          end
          else if (stop_hit)
            ev_set_r[`PDMM_EV_STOPPED] <= 1'b1;
        end
        ST_RUN:
        begin
          if (stop_hit)
            stop_req_r <= 1'b1;
          // Fall edge channel is left unless swapped
          if (fall)
          begin
            if (mode_r[`PDMM_MODE_SWAP])
              accr_r <= accr_r + {6'h00, din};
            else
              accl_r <= accl_r + {6'h00, din};
            bit_r <= bit_r + 6'h01;
            if (bit_r == `PDMM_FRAME_LAST)
              frame_r <= 1'b1;
          end
          if (rise)
          begin
            if (mode_r[`PDMM_MODE_SWAP])
              accl_r <= accl_r + {6'h00, din};
            else
              accr_r <= accr_r + {6'h00, din};
          end
          // Frame done: no edge can fall here, phases are two cycles or more
          if (frame_r)
          begin
            accl_r <= 7'h00;
            accr_r <= 7'h00;
            cnt_r  <= cnt_n[15:0];
            if (wr_word)
            begin
              mem_we    <= 1'b1;
              mem_addr  <= act_ptr_r;
              mem_wdata <= word;
              act_ptr_r <= act_ptr_r + 32'h00000004;
              half_r    <= 1'b0;
            end
            else
            begin
              hold_r <= samp_l;
              half_r <= 1'b1;
            end
            // Stop acts only here, once the frame is written
            if (stop_req_r)
            begin
              state_r                    <= ST_IDLE;
              ev_set_r[`PDMM_EV_END]     <= 1'b1;
              ev_set_r[`PDMM_EV_STOPPED] <= 1'b1;
            end
            else if (full)
            begin
              // Swap to the pointer software has staged
              act_ptr_r                  <= ptr_r;
              act_max_r                  <= max_r;
              cnt_r                      <= 16'h0000;
              ev_set_r[`PDMM_EV_END]     <= 1'b1;
              ev_set_r[`PDMM_EV_STARTED] <= 1'b1;
            end
          end
          // Disabling mid-capture aborts with no events
          if (!en_r)
            state_r <= ST_IDLE;
        end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // Pin drive; clock select wins if both name one pin
  always @(posedge clk)
  begin : pin_drive
    integer i;
    if (!resetn)
    begin
      pin_out <= 32'h00000000;
      pin_oe  <= 32'h00000000;
    end
    else
    begin
      for (i = 0; i < 32; i = i + 1)
      begin
        if (clk_conn && psel_clk_r[4:0] == i[4:0])
        begin
          pin_out[i] <= bclk;
          pin_oe[i]  <= 1'b1;
        end
        else if (din_conn && psel_din_r[4:0] == i[4:0])
        begin
          pin_out[i] <= gpio_out[i];
          pin_oe[i]  <= 1'b0;
        end
        else
        begin
          pin_out[i] <= gpio_out[i];
          pin_oe[i]  <= gpio_oe[i];
        end
      end
    end
  end

  // Read data, one cycle after the strobe; triggers and holes read zero
  always @(posedge clk)
  begin
    if (!resetn)
      reg_rdata <= 32'h00000000;
    else if (!reg_rd)
      reg_rdata <= 32'h00000000;
    else if (reg_addr == `PDMM_A_EV_STA)
      reg_rdata <= {31'h00000000, ev_r[`PDMM_EV_STARTED]};
    else if (reg_addr == `PDMM_A_EV_STO)
      reg_rdata <= {31'h00000000, ev_r[`PDMM_EV_STOPPED]};
    else if (reg_addr == `PDMM_A_EV_END)
      reg_rdata <= {31'h00000000, ev_r[`PDMM_EV_END]};
    else if (reg_addr == `PDMM_A_IRQ_ENABLE || reg_addr == `PDMM_A_INTSET ||
             reg_addr == `PDMM_A_INTCLR)
      reg_rdata <= {29'h00000000, irq_enable_r};
    else if (reg_addr == `PDMM_A_ENABLE)
      reg_rdata <= {31'h00000000, en_r};
    else if (reg_addr == `PDMM_A_CLKCTL)
      reg_rdata <= {24'h000000, clkctl_r};
    else if (reg_addr == `PDMM_A_MODE)
      reg_rdata <= {30'h00000000, mode_r};
    else if (reg_addr == `PDMM_A_LEFT_GAIN)
      reg_rdata <= {25'h0000000, left_gain_r};
    else if (reg_addr == `PDMM_A_RIGHT_GAIN)
      reg_rdata <= {25'h0000000, right_gain_r};
    else if (reg_addr == `PDMM_A_PSELCLK)
      reg_rdata <= psel_clk_r;
    else if (reg_addr == `PDMM_A_PSELDIN)
      reg_rdata <= psel_din_r;
    else if (reg_addr == `PDMM_A_PTR)
      reg_rdata <= ptr_r;
    else if (reg_addr == `PDMM_A_MAXCNT)
      reg_rdata <= {16'h0000, max_r};
    else
      reg_rdata <= 32'h00000000;
  end

endmodule

`default_nettype wire

//--- verilog/pdmm_map.vh
// Purpose: Register offsets, field positions, resets and timing counts
// Assumes: 12-bit byte address on the register port
// Notes:   Definitions only
`ifndef PDMM_MAP_VH
`define PDMM_MAP_VH

// Register byte offsets
`define PDMM_A_START    12'h000
`define PDMM_A_STOP     12'h004
`define PDMM_A_EV_STA   12'h100
`define PDMM_A_EV_STO   12'h104
`define PDMM_A_EV_END   12'h108
`define PDMM_A_IRQ_ENABLE    12'h300
`define PDMM_A_INTSET   12'h304
`define PDMM_A_INTCLR   12'h308
`define PDMM_A_ENABLE   12'h500
`define PDMM_A_CLKCTL   12'h504
`define PDMM_A_MODE     12'h508
`define PDMM_A_LEFT_GAIN    12'h518
`define PDMM_A_RIGHT_GAIN    12'h51C
`define PDMM_A_PSELCLK  12'h540
`define PDMM_A_PSELDIN  12'h544
`define PDMM_A_PTR      12'h560
`define PDMM_A_MAXCNT   12'h564

// Event bit positions (flags and interrupt enables)
`define PDMM_EV_STARTED 0
`define PDMM_EV_STOPPED 1
`define PDMM_EV_END     2

// Field positions
`define PDMM_PSEL_DISC  31
`define PDMM_MODE_MONO  0
`define PDMM_MODE_SWAP  1

// Reset values
`define PDMM_PSEL_RST   32'hFFFFFFFF
`define PDMM_CLKCTL_RST 8'h04
`define PDMM_GAIN_RST   7'h00

// Timing counts: half period floor in system clock cycles, last frame bit in bit clock periods
`define PDMM_HP_MIN     8'h02
`define PDMM_FRAME_LAST 6'h3F

`endif

//--- verilog/pdmm_sync.v
// Purpose: Two-flop synchroniser for a bank of pin inputs
// Assumes: Inputs are asynchronous to clk
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none

module pdmm_sync
#(
  parameter W = 32
)
(
  input  wire         clk,
  input  wire         resetn,
  input  wire [W-1:0] async_in,
  output reg  [W-1:0] sync_out
);

  reg [W-1:0] meta_r; // First stage, metastability catcher

  // Two stages, cleared by synchronous reset
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      meta_r   <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end
    else
    begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

`default_nettype wire

//--- verilog/pdmm_bclk.v
// Purpose: Bit clock generator with edge enable pulses
// Assumes: half_period counts system cycles per clock phase
// Notes:   Clock idles low, matching the parked pin level
`timescale 1ns/1ps
`default_nettype none
`include "pdmm_map.vh"

module pdmm_bclk
(
  input  wire       clk,
  input  wire       resetn,
  input  wire       run,
  input  wire [7:0] half_period,
  output reg        bclk,
  output reg        rise,
  output reg        fall
);

  reg  [7:0] cnt_r; // Phase counter
  wire [7:0] hp;    // Clamped half period

  // Short phases would let a frame end collide with the next edge
  assign hp = (half_period < `PDMM_HP_MIN) ? `PDMM_HP_MIN : half_period;

  // Divider, stopped and low while not running
  always @(posedge clk)
  begin
    if (!resetn || !run)
    begin
      cnt_r <= 8'h00;
      bclk  <= 1'b0;
      rise  <= 1'b0;
      fall  <= 1'b0;
    end
    else if (cnt_r == hp - 8'h01)
    begin
      cnt_r <= 8'h00;
      bclk  <= ~bclk;
      rise  <= ~bclk;
      fall  <= bclk;
    end
    else
    begin
      cnt_r <= cnt_r + 8'h01;
      rise  <= 1'b0;
      fall  <= 1'b0;
    end
  end

endmodule

`default_nettype wire

//--- sim/pdmm_chk.sv
// Purpose: Port-level checks for the microphone unit
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound onto pdmm_top
`timescale 1ns/1ps
`default_nettype none
module pdmm_chk
(
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        power_off,
  input wire logic [31:0] gpio_out,
  input wire logic [31:0] gpio_oe,
  input wire logic [31:0] pin_in,
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic        mem_we,
  input wire logic        irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Set once software touches any irq enable; irq cannot rise before
  logic en_seen_r;
  always_ff @(posedge clk)
    if (!resetn)
      en_seen_r <= 1'b0;
    else if (reg_wr && reg_addr[11:4] == 8'h30)
      en_seen_r <= 1'b1;
  trig_zero_a: assert property (reg_rd && reg_addr[11:3] == 9'h0 |=> reg_rdata == 32'h0)
    else $error("trigger read not zero");
  unmap_zero_a: assert property (reg_rd && reg_addr == 12'hFFC |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  flag_bits_a: assert property (reg_rd && reg_addr[11:4] == 8'h10 |=> reg_rdata[31:1] == 31'h0)
    else $error("flag upper bits set");
  en_bits_a: assert property (reg_rd && reg_addr == 12'h500 |=> reg_rdata[31:1] == 31'h0)
    else $error("enable upper bits set");
  psel_lost_a: assert property ($fell(power_off) && !reg_wr ##1 reg_rd && reg_addr[11:3] == 9'hA8
                                |=> reg_rdata == 32'hFFFFFFFF)
    else $error("pin select kept after power off");
  we_gap_a: assert property (mem_we |=> !mem_we [*8])
    else $error("memory writes too close");
  irq_quiet_a: assert property (!en_seen_r |-> !irq)
    else $error("irq without enable");
  irq_off_a: assert property (reg_wr && reg_addr == 12'h308 && reg_wdata[2:0] == 3'h7 |-> ##2 !irq)
    else $error("irq after enables cleared");
  off_gpio_a: assert property (power_off [*2] |=> pin_oe == gpio_oe && pin_out == gpio_out)
    else $error("pins not back to gpio");
endmodule
bind pdmm_top pdmm_chk u_chk
(
  .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .power_off(power_off), .gpio_out(gpio_out),
  .gpio_oe(gpio_oe), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .mem_addr(mem_addr),
  .mem_wdata(mem_wdata), .mem_we(mem_we), .irq(irq)
);
`default_nettype wire

//--- sim/pdmm_mic.sv
// Purpose: Behavioural left-slot microphone
// Assumes: Bit clock idles low between captures
// Notes:   Drives 1 in its slot, releases the line in the other
`timescale 1ns/1ps
`default_nettype none
module pdmm_mic
(
  input  wire logic bclk,
  output var  logic dout
);
  // Power-up line level
  initial dout = 1'b0;
  // Own slot follows the rising edge, read on the falling one
  always @(posedge bclk)
    dout <= #20 1'b1;
  // Released line shows the inverse of the last value
  always @(negedge bclk)
    dout <= #20 ~dout;
endmodule
`default_nettype wire

//--- sim/pdmm_top_tb.sv
// Purpose: Self-checking bench for the microphone unit
// Assumes: 10 MHz clock, one left microphone on pin 7, clock on pin 3
// Notes:   Expected words follow from an all-ones left stream
`timescale 1ns/1ps
`default_nettype none
module pdmm_top_tb;
  logic        clk, resetn, reg_wr, reg_rd, power_off, mem_we, irq, mic_dat;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, gpio_out, gpio_oe, pin_out, pin_oe, mem_addr, mem_wdata;
  wire  [31:0] pin_in;
  wire         mic_clk;
  integer      bad_count, n_checks;
  // Register table: offset, reset value, value after writing all ones
  logic [11:0] ra [0:10] = '{12'h500, 12'h504, 12'h508, 12'h518, 12'h51C, 12'h540, 12'h544,
                             12'h560, 12'h564, 12'h300, 12'hFFC};
  logic [31:0] rv [0:10] = '{32'h0, 32'h4, 32'h0, 32'h0, 32'h0, 32'hFFFFFFFF, 32'hFFFFFFFF,
                             32'h0, 32'h0, 32'h0, 32'h0};
  logic [31:0] rm [0:10] = '{32'h1, 32'hFF, 32'h3, 32'h7F, 32'h7F, 32'hFFFFFFFF, 32'hFFFFFFFF,
                             32'hFFFFFFFF, 32'hFFFF, 32'h7, 32'h0};
  // Wire levels: driven pins loop back, pin 7 carries the microphone
  assign pin_in  = (pin_out & pin_oe) | (({31'h0, mic_dat} << 7) & ~pin_oe);
  assign mic_clk = pin_out[3] & pin_oe[3];
  pdmm_top dut
  (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .power_off(power_off), .gpio_out(gpio_out),
    .gpio_oe(gpio_oe), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_we(mem_we), .irq(irq)
  );
  pdmm_mic mic
  (
    .bclk(mic_clk),
    .dout(mic_dat)
  );
  // 100 ns system clock
  always #50 clk = ~clk;
  // Compare and count
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp)
      begin
        bad_count = bad_count + 1;
        $display("mismatch %s exp %h seen %h", what, exp, seen);
      end
    end
  endtask
  // One write cycle
  task wr(input logic [11:0] a, input logic [31:0] d);
    begin
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
    end
  endtask
  // Read, data taken in the following cycle only
  task rc(input logic [11:0] a, input logic [31:0] e);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1 chk($sformatf("reg %h", a), reg_rdata, e);
    end
  endtask
  // Wait for a memory write; a hang counts as a mismatch
  task wait_we;
    integer n;
    begin
      n = 0;
      do
      begin
        @(posedge clk);
        #1 n = n + 1;
      end
      while (mem_we !== 1'b1 && n < 3000);
      if (mem_we !== 1'b1)
        bad_count = bad_count + 1;
    end
  endtask
  // Reset values, field widths, triggers, unmapped place, irq enables
  task regs;
    integer i;
    begin
      for (i = 0; i < 11; i++)
        rc(ra[i], rv[i]);
      for (i = 0; i < 11; i++)
        wr(ra[i], 32'hFFFFFFFF);
      for (i = 0; i < 11; i++)
        rc(ra[i], rm[i]);
      rc(12'h000, 32'h0);
      rc(12'h004, 32'h0);
      wr(12'h000, 32'h0);
      rc(12'h100, 32'h0);
      wr(12'h004, 32'h1);
      rc(12'h104, 32'h1);
      wr(12'h104, 32'h0);
      wr(12'h308, 32'h2);
      rc(12'h300, 32'h5);
      wr(12'h304, 32'h2);
      rc(12'h304, 32'h7);
      wr(12'h308, 32'h7);
      rc(12'h308, 32'h0);
      wr(12'h500, 32'h0);
      wr(12'h504, 32'h4);
    end
  endtask
  // Pin routing against gpio fallback
  task pins;
    begin
      #1 chk("out", pin_out, gpio_out);
      wr(12'h540, 32'hC);
      wr(12'h544, 32'h9);
      repeat (2) @(posedge clk);
      #1 chk("oe", pin_oe, gpio_oe);
      wr(12'h500, 32'h1);
      repeat (2) @(posedge clk);
      #1 chk("oe", pin_oe, (gpio_oe | 32'h1000) & ~32'h200);
      chk("out", pin_out, gpio_out);
      wr(12'h544, 32'h80000009);
      repeat (2) @(posedge clk);
      #1 chk("oe", pin_oe, gpio_oe | 32'h1000);
      power_off <= 1'b1;
      repeat (2) @(posedge clk);
      power_off <= 1'b0;
      #1 chk("oe", pin_oe, gpio_oe);
      rc(12'h540, 32'hFFFFFFFF);
      wr(12'h540, 32'h3);
      wr(12'h544, 32'h7);
    end
  endtask
  // Capture one buffer of two words, reload, stop mid-buffer
  task cap(input logic [1:0] mode, input logic [31:0] w);
    integer i;
    begin
      wr(12'h508, {30'h0, mode});
      wr(12'h560, 32'h2000);
      wr(12'h564, 32'h4);
      wr(12'h300, 32'h5);
      wr(12'h000, 32'h1);
      rc(12'h100, 32'h1);
      @(posedge clk);
      #1 chk("irq", {31'h0, irq}, 32'h1);
      wr(12'h100, 32'h0);
      wr(12'h560, 32'h3000);
      for (i = 0; i < 2; i++)
      begin
        wait_we;
        chk("addr", mem_addr, 32'h2000 + 4 * i);
        chk("data", mem_wdata, w);
      end
      repeat (2) @(posedge clk);
      rc(12'h108, 32'h1);
      rc(12'h100, 32'h1);
      wr(12'h108, 32'h0);
      wr(12'h004, 32'h1);
      rc(12'h104, 32'h0);
      wait_we;
      chk("addr", mem_addr, 32'h3000);
      repeat (2) @(posedge clk);
      rc(12'h104, 32'h1);
      rc(12'h108, 32'h1);
      wr(12'h108, 32'h0);
      wr(12'h100, 32'h0);
      wr(12'h104, 32'h0);
      rc(12'h104, 32'h0);
      chk("irq", {31'h0, irq}, 32'h0);
    end
  endtask
  // Verdict and end of run
  task results;
    begin
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  // Run needs about 6000 cycles
  initial
  begin
    repeat (40000) @(posedge clk);
    bad_count = bad_count + 1;
    results;
  end
  // Main sequence
  initial
  begin
    clk       = 1'b0;
    resetn    = 1'b0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 12'h0;
    reg_wdata = 32'h0;
    power_off = 1'b0;
    gpio_out  = 32'h00000F00;
    gpio_oe   = 32'h00000F08;
    bad_count = 0;
    n_checks  = 0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    regs;
    pins;
    cap(2'h0, 32'h80000000);
    cap(2'h2, 32'h00008000);
    cap(2'h1, 32'h00000000);
    results;
  end
endmodule
`default_nettype wire
